// ### logic/adc_serial_ctrl.sv
// Purpose: Conversion control and serial result output of a sampling converter.
// Assumes: sar_sample is valid from the analog core while busy is low.
// Notes: The internal shift clock is one high and two low core cycles per bit.
// What this block does
// - Busy falls when a conversion starts.
// - Busy rises on the same core clock edge that latches the result into the output register.
// - Device select is ORed with read/convert before edges are judged.
// - Serial bits follow the shift clock in the selected number coding.
// - External clock: after 16 bits, pass the tag level while selected and reading.
// - Internal clock: each bit valid at shift clock rise and through its fall.
// - Internal clock: between transmissions output holds tag sampled at conversion start.
// - Shift clock pin drives out in internal mode, is an input in external mode.
// - Internal clock: exactly 16 pulses per conversion start, then held low.
// - External clock: host supplies the shift clock, result shifts on it.
// - Internal clock: each convert also sends the previous result with its pulses.
// - Power down ignores convert requests and enters low consumption.
// - Power down keeps the last completed result.
// - Falling read/convert with select low holds the sample and starts converting.
// - External clock: read window opening sends a frame pulse and the previous result.
// - Straight binary when format select is high, two's complement when low.
// - Internal shift clock exists only while a result is being sent.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_ctrl #(
  parameter int WIDTH = adc_serial_pkg::WORD_BITS,
  parameter int CONV_CYCLES = adc_serial_pkg::CONV_CYCLES
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control pins
  input wire logic read_convert_n,
  input wire logic device_select_n,
  input wire logic shift_clock_source_select,
  input wire logic code_format_select,
  input wire logic power_down_in,
  input wire logic daisy_chain_input,
  // Analog core
  input wire logic [WIDTH-1:0] sar_sample,
  output logic hold_out,
  output logic low_power_out,
  // Status and serial output
  output logic busy_n,
  output logic serial_data_out,
  output logic frame_pulse_out,
  // Shift clock pin
  input wire logic serial_shift_clock_in,
  output logic serial_shift_clock_out,
  output logic serial_shift_clock_oe
);
  function automatic logic [WIDTH-1:0] format_word(input logic [WIDTH-1:0] raw,
                                                   input logic straight);
    format_word = straight ? raw : {~raw[WIDTH-1], raw[WIDTH-2:0]};
  endfunction

  logic [adc_serial_pkg::PIN_COUNT-1:0] pins_raw;
  logic [adc_serial_pkg::PIN_COUNT-1:0] pins_s;
  assign pins_raw = {code_format_select, shift_clock_source_select, power_down_in,
                     daisy_chain_input, device_select_n, read_convert_n};

  sync_two_flop #(.WIDTH(adc_serial_pkg::PIN_COUNT), .INIT(6'h03)) pin_sync (
    .clk(core_clk),
    .rst(sys_rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  wire rc_s = pins_s[adc_serial_pkg::PIN_RC];
  wire cs_s = pins_s[adc_serial_pkg::PIN_CS];
  wire tag_s = pins_s[adc_serial_pkg::PIN_TAG];
  wire pd_s = pins_s[adc_serial_pkg::PIN_PD];
  wire ext_s = pins_s[adc_serial_pkg::PIN_EXT];
  wire fmt_s = pins_s[adc_serial_pkg::PIN_FMT];

  // Combined request level and read window, judged from the previous cycle.
  logic cmd_prev_reg;
  logic window_prev_reg;
  wire cmd_n = rc_s | cs_s;
  wire window = rc_s & ~cs_s;
  wire convert_req = cmd_prev_reg & ~cmd_n;
  wire start_conv = convert_req & ~pd_s & busy_n;
  wire frame_req = ext_s & window & ~window_prev_reg;

  // Conversion timing and result latch.
  logic [15:0] conv_cnt_reg;
  logic [WIDTH-1:0] result_reg;
  logic tag_hold_reg;
  wire conv_last = conv_cnt_reg == 16'(CONV_CYCLES - 1);
  wire conv_done = ~busy_n & conv_last;

  // Edge history of the combined request and of the read window.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_prev_reg <= 1'b1;
      window_prev_reg <= 1'b0;
    end else begin
      cmd_prev_reg <= cmd_n;
      window_prev_reg <= window;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      low_power_out <= 1'b0;
    end else begin
      low_power_out <= pd_s;
    end
  end

  // Busy and hold mark one conversion, from its start to the latch of its result.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_n <= 1'b1;
      hold_out <= 1'b0;
    end else if (start_conv) begin
      busy_n <= 1'b0;
      hold_out <= 1'b1;
    end else if (conv_done) begin
      busy_n <= 1'b1;
      hold_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || start_conv) begin
      conv_cnt_reg <= 16'h0000;
    end else if (!busy_n && !conv_last) begin
      conv_cnt_reg <= conv_cnt_reg + 16'h0001;
    end
  end

  // The tag level is taken once per start and shown between transmissions.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tag_hold_reg <= 1'b0;
    end else if (start_conv) begin
      tag_hold_reg <= tag_s;
    end
  end

  // Only a finished conversion writes the result, so power down keeps the last one.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result_reg <= adc_serial_pkg::RESULT_RESET;
    end else if (conv_done) begin
      result_reg <= sar_sample;
    end
  end

  // Internal shift clock transmitter.
  adc_serial_pkg::tx_state_type tx_state_reg;
  adc_serial_pkg::tx_state_type tx_state_next;
  logic [WIDTH-1:0] tx_shift_reg;
  logic [4:0] tx_bit_reg;
  logic int_data_reg;
  logic ext_mode_reg;
  wire int_start = start_conv & ~ext_s;
  wire [WIDTH-1:0] out_word = format_word(result_reg, fmt_s);
  wire tx_last = tx_bit_reg == adc_serial_pkg::LAST_BIT_INDEX;
  wire tx_hold = tx_state_reg == adc_serial_pkg::TX_HOLD;
  wire tx_idle = tx_state_reg == adc_serial_pkg::TX_IDLE;

  // Each bit takes three cycles: new data with the clock low, clock high, clock low.
  always_comb begin
    tx_state_next = adc_serial_pkg::TX_IDLE;
    if (int_start) begin
      tx_state_next = adc_serial_pkg::TX_SETUP;
    end else begin
      case (tx_state_reg)
        adc_serial_pkg::TX_SETUP: begin
          tx_state_next = adc_serial_pkg::TX_HIGH;
        end
        adc_serial_pkg::TX_HIGH: begin
          tx_state_next = adc_serial_pkg::TX_HOLD;
        end
        adc_serial_pkg::TX_HOLD: begin
          if (!tx_last) begin
            tx_state_next = adc_serial_pkg::TX_SETUP;
          end
        end
        default: begin
          tx_state_next = adc_serial_pkg::TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_state_reg <= adc_serial_pkg::TX_IDLE;
      serial_shift_clock_out <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      serial_shift_clock_out <= tx_state_next == adc_serial_pkg::TX_HIGH;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext_mode_reg <= 1'b0;
      serial_shift_clock_oe <= 1'b0;
    end else begin
      ext_mode_reg <= ext_s;
      serial_shift_clock_oe <= ~ext_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_shift_reg <= adc_serial_pkg::RESULT_RESET;
      tx_bit_reg <= 5'h00;
    end else if (int_start) begin
      tx_shift_reg <= out_word;
      tx_bit_reg <= 5'h00;
    end else if (tx_hold && !tx_last) begin
      tx_shift_reg <= tx_shift_reg << 1;
      tx_bit_reg <= tx_bit_reg + 5'h01;
    end
  end

  // After the last bit, and while idle in internal mode, the line shows the held tag.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      int_data_reg <= 1'b0;
    end else if (int_start) begin
      int_data_reg <= out_word[WIDTH-1];
    end else if (tx_hold && !tx_last) begin
      int_data_reg <= tx_shift_reg[WIDTH-2];
    end else if (tx_hold || (tx_idle && !ext_s)) begin
      int_data_reg <= tag_hold_reg;
    end
  end

  // Frame request crosses to the link clock as a toggle with a stable word.
  logic frame_toggle_reg;
  logic [WIDTH-1:0] frame_word_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      frame_toggle_reg <= 1'b0;
      frame_word_reg <= adc_serial_pkg::RESULT_RESET;
    end else if (frame_req) begin
      frame_toggle_reg <= ~frame_toggle_reg;
      frame_word_reg <= out_word;
    end
  end

  // Link domain, clocked by the host's shift clock.
  logic link_rst;
  logic [3:0] link_s;

  sync_two_flop #(.WIDTH(1), .INIT(1'b1)) link_rst_sync (
    .clk(serial_shift_clock_in),
    .rst(1'b0),
    .async_in(sys_rst),
    .sync_out(link_rst)
  );

  sync_two_flop #(.WIDTH(4), .INIT(4'h3)) link_sync (
    .clk(serial_shift_clock_in),
    .rst(link_rst),
    .async_in({frame_toggle_reg, daisy_chain_input, device_select_n, read_convert_n}),
    .sync_out(link_s)
  );

  logic link_toggle_reg;
  logic [WIDTH-1:0] ext_shift_reg;
  logic [4:0] ext_cnt_reg;
  logic ext_data_reg;
  wire link_frame = link_s[3] ^ link_toggle_reg;
  wire link_window = link_s[0] & ~link_s[1];
  wire ext_done = ext_cnt_reg == adc_serial_pkg::EXT_DONE_COUNT;
  wire ext_sending = ext_cnt_reg != 5'h00 && !ext_done;

  always_ff @(posedge serial_shift_clock_in) begin
    if (link_rst) begin
      link_toggle_reg <= 1'b0;
      frame_pulse_out <= 1'b0;
    end else begin
      link_toggle_reg <= link_s[3];
      frame_pulse_out <= link_frame;
    end
  end

  always_ff @(posedge serial_shift_clock_in) begin
    if (link_rst) begin
      ext_shift_reg <= adc_serial_pkg::RESULT_RESET;
      ext_cnt_reg <= 5'h00;
      ext_data_reg <= 1'b0;
    end else if (link_frame) begin
      ext_shift_reg <= frame_word_reg << 1;
      ext_data_reg <= frame_word_reg[WIDTH-1];
      ext_cnt_reg <= 5'h01;
    end else if (ext_sending) begin
      ext_data_reg <= ext_shift_reg[WIDTH-1];
      ext_shift_reg <= ext_shift_reg << 1;
      ext_cnt_reg <= ext_cnt_reg + 5'h01;
    end else if (ext_done) begin
      ext_data_reg <= link_window & link_s[2];
    end
  end

  assign serial_data_out = ext_mode_reg ? ext_data_reg : int_data_reg;
endmodule
`default_nettype wire

// ### logic/adc_serial_pkg.sv
// Purpose: Shared constants for the converter control and serial result logic.
// Assumes: Core clock of 10 MHz.
// Notes: Times are kept in ns with their cycle counts derived here.
package adc_serial_pkg;
  localparam int CORE_CLK_NS = 100;
  localparam int CONV_TIME_NS = 2200;
  localparam int CONV_CYCLES = (CONV_TIME_NS / CORE_CLK_NS) < 1 ? 1 : (CONV_TIME_NS / CORE_CLK_NS);
  localparam int WORD_BITS = 16;
  localparam logic [4:0] LAST_BIT_INDEX = 5'h0f;
  localparam logic [4:0] EXT_DONE_COUNT = 5'h10;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int PIN_RC = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_TAG = 2;
  localparam int PIN_PD = 3;
  localparam int PIN_EXT = 4;
  localparam int PIN_FMT = 5;
  localparam int PIN_COUNT = 6;
  typedef enum logic [1:0] {TX_IDLE, TX_SETUP, TX_HIGH, TX_HOLD} tx_state_type;
endpackage

// ### logic/sync_two_flop.sv
// Purpose: Two flip-flop synchroniser for a vector of independent levels.
// Assumes: Each bit is a slow level; bits are not related to each other.
// Notes: Only the second stage leaves this module.
`timescale 1ns/1ns
`default_nettype none
module sync_two_flop #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage_reg <= INIT;
      sync_out <= INIT;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule
`default_nettype wire

// ### tb/adc_serial_asserts.sv
// Purpose: Port checker for the converter control and serial output block.
// Assumes: Bound to adc_serial_ctrl.
// Notes: Link properties run on the shift clock input.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_asserts #(
  parameter int CONV_CYCLES = 22
) (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic serial_shift_clock_in,
  // Watched pins
  input wire logic shift_clock_source_select,
  input wire logic power_down_in,
  input wire logic busy_n,
  input wire logic hold_out,
  input wire logic serial_data_out,
  input wire logic frame_pulse_out,
  input wire logic serial_shift_clock_out,
  input wire logic serial_shift_clock_oe
);
  logic [7:0] low_cnt_reg;
  always_ff @(posedge core_clk) begin
    low_cnt_reg <= (sys_rst || busy_n) ? 8'h00 : low_cnt_reg + 8'h01;
  end
  a_busy_hold: assert property (@(posedge core_clk) disable iff (sys_rst) hold_out == !busy_n)
    else $error("hold and busy disagree");
  a_busy_len: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(busy_n) |-> low_cnt_reg == CONV_CYCLES) else $error("busy low time wrong");
  a_oe_int: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!shift_clock_source_select)[*4] |-> serial_shift_clock_oe) else $error("clock pin not driven");
  a_oe_ext: assert property (@(posedge core_clk) disable iff (sys_rst)
    shift_clock_source_select[*4] |-> !serial_shift_clock_oe) else $error("clock pin driven");
  a_clk_owner: assert property (@(posedge core_clk) disable iff (sys_rst)
    serial_shift_clock_out |-> serial_shift_clock_oe) else $error("clock pulse while not driving");
  a_pulse_short: assert property (@(posedge core_clk) disable iff (sys_rst)
    serial_shift_clock_out |=> !serial_shift_clock_out) else $error("shift clock high too long");
  a_bit_stable: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(serial_shift_clock_out) |-> $stable(serial_data_out) ##1 $stable(serial_data_out))
    else $error("data moved around shift clock pulse");
  a_pd_refuse: assert property (@(posedge core_clk) disable iff (sys_rst)
    power_down_in[*4] ##0 busy_n |=> busy_n) else $error("conversion in power down");
  a_frame_single: assert property (@(posedge serial_shift_clock_in) disable iff (sys_rst)
    frame_pulse_out |=> !frame_pulse_out) else $error("frame pulse too long");
endmodule
bind adc_serial_ctrl adc_serial_asserts #(.CONV_CYCLES(CONV_CYCLES)) i_chk (.core_clk,
  .sys_rst, .serial_shift_clock_in, .shift_clock_source_select, .power_down_in, .busy_n,
  .hold_out, .serial_data_out, .frame_pulse_out, .serial_shift_clock_out, .serial_shift_clock_oe);
`default_nettype wire

// ### tb/host_link.sv
// Purpose: Host model that clocks and captures external mode results.
// Assumes: Link clock period 160 ns, still while run is low.
// Notes: Bits are taken on the falling edge of the pin.
`timescale 1ns/1ns
`default_nettype none
module host_link (
  // Control and pins
  input wire logic run,
  input wire logic pin,
  input wire logic data,
  input wire logic frame,
  // Clock and capture
  output logic sclk,
  output logic [15:0] word,
  output logic [4:0] nbits
);
  initial begin
    sclk = 1'b0;
    word = 16'h0000;
    nbits = 5'h00;
    #30;
    forever begin
      #80;
      sclk = run ? !sclk : 1'b0;
    end
  end
  always @(negedge pin) begin
    if (frame) begin
      word <= {15'h0000, data};
      nbits <= 5'h01;
    end else if (nbits < 5'h10) begin
      word <= {word[14:0], data};
      nbits <= nbits + 5'h01;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_sar_adc_serial_interface.sv
// Purpose: Self-checking bench for the converter control and serial output.
// Assumes: CONV_CYCLES shortened to 3.
// Notes: Each row converts twice so the second transmission shows the row.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module tb_sar_adc_serial_interface;
  typedef struct packed {logic [15:0] s; logic f; logic t; logic [15:0] e;} row_type;
  row_type rows [4] = '{'{16'h1234, 1'b1, 1'b1, 16'h1234}, '{16'hA5C3, 1'b0, 1'b0, 16'h25C3},
    '{16'hFFFF, 1'b1, 1'b0, 16'hFFFF}, '{16'h0001, 1'b0, 1'b1, 16'h8001}};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic read_convert_n = 1'b1, device_select_n = 1'b0, shift_clock_source_select = 1'b0;
  logic code_format_select = 1'b1, power_down_in = 1'b0, daisy_chain_input = 1'b0, run = 1'b1;
  logic [15:0] sar_sample = 16'h0000;
  logic [15:0] int_word = 16'h0000;
  logic [15:0] host_word;
  logic [4:0] host_bits;
  logic busy_n, hold_out, low_power_out, serial_data_out, frame_pulse_out;
  logic sck_out, sck_oe, host_sck;
  wire logic sck_pin;
  int pulses = 0, frames = 0, miscompares = 0, n_compared = 0, cycles = 0;
  assign sck_pin = sck_oe ? sck_out : host_sck;
  adc_serial_ctrl #(.CONV_CYCLES(3)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .read_convert_n(read_convert_n), .device_select_n(device_select_n),
    .shift_clock_source_select(shift_clock_source_select), .code_format_select(code_format_select),
    .power_down_in(power_down_in), .daisy_chain_input(daisy_chain_input), .sar_sample(sar_sample),
    .hold_out(hold_out), .low_power_out(low_power_out), .busy_n(busy_n),
    .serial_data_out(serial_data_out), .frame_pulse_out(frame_pulse_out),
    .serial_shift_clock_in(sck_pin), .serial_shift_clock_out(sck_out), .serial_shift_clock_oe(sck_oe));
  host_link i_host (.run(run), .pin(sck_pin), .data(serial_data_out), .frame(frame_pulse_out),
    .sclk(host_sck), .word(host_word), .nbits(host_bits));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (sck_out) begin
      int_word <= {int_word[14:0], serial_data_out};
      pulses <= pulses + 1;
    end
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  always @(posedge sck_pin) begin
    if (frame_pulse_out) frames <= frames + 1;
  end
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Holds the convert pin low six cycles, then lets busy and any transmission finish.
  task automatic convert();
    int k;
    pulses = 0;
    @(posedge core_clk) read_convert_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    read_convert_n <= 1'b1;
    k = 0;
    while (busy_n !== 1'b1 && k < 100) begin
      @(posedge core_clk);
      k++;
    end
    repeat (60) @(posedge core_clk);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    run <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK(busy_n, 1'b1)
    foreach (rows[i]) begin
      sar_sample <= rows[i].s;
      convert();
      code_format_select <= rows[i].f;
      daisy_chain_input <= rows[i].t;
      convert();
      daisy_chain_input <= !rows[i].t;
      repeat (5) @(posedge core_clk);
      `CHK(int_word, rows[i].e)
      `CHK(pulses, 16)
      `CHK(serial_data_out, rows[i].t)
    end
    device_select_n <= 1'b1;
    convert();
    `CHK(pulses, 0)
    device_select_n <= 1'b0;
    code_format_select <= 1'b1;
    sar_sample <= 16'h0F0F;
    convert();
    power_down_in <= 1'b1;
    sar_sample <= 16'hC33C;
    repeat (5) @(posedge core_clk);
    convert();
    `CHK(low_power_out, 1'b1)
    `CHK(pulses, 0)
    power_down_in <= 1'b0;
    repeat (5) @(posedge core_clk);
    convert();
    `CHK(int_word, 16'h0F0F)
    shift_clock_source_select <= 1'b1;
    daisy_chain_input <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(sck_oe, 1'b0)
    convert();
    run <= 1'b1;
    repeat (50) @(posedge core_clk);
    `CHK(host_word, 16'hC33C)
    `CHK(host_bits, 5'h10)
    `CHK(frames, 1)
    `CHK(serial_data_out, 1'b1)
    run <= 1'b0;
    report_and_stop();
  end
endmodule
`default_nettype wire
